// ==== bench/fpzl_fan_model.sv ====
/* Fan model: answers a measure request with a tach reading four cycles later.
   Assumes one reading at a time is requested. */
`timescale 1ns/10ps
// ======================================================================
module fpzl_fan_model (
  input  wire logic        clk,               // Device clock.
  input  wire logic        measure,           // Start a reading.
  input  wire logic [15:0] period,            // Count returned.
  output logic             sampling,          // Reading in progress.
  output logic             tach_valid = 1'b0, // Reading done, one cycle.
  output logic [15:0]      tach_count = 16'h0 // Reading.
);
  logic [2:0] left = 3'h0;
  // The count toggles outside the valid cycle, so a stale value never passes.
  always_ff @(posedge clk) begin
    left       <= measure ? 3'h4 : left - {2'h0, left != 3'h0};
    tach_valid <= (left == 3'h1);
    tach_count <= (left == 3'h1) ? period : ~tach_count;
  end
  assign sampling = (left != 3'h0);
endmodule

// ==== bench/fpzl_top_asserts.sv ====
/* Checker of the fan block top ports: status flags, lock latch, tach hold.
   Assumes it is bound to fpzl_top and sees only its ports. */
`timescale 1ns/10ps
// ======================================================================
module fpzl_top_asserts (
  input wire logic CLK,              // Device clock.
  input wire logic RST_N,            // Reset, active low.
  input wire logic TEMP_VALID,       // New temperatures.
  input wire logic TACH_VALID,       // New tach reading.
  input wire logic STATUS_CLEAR,     // Flag clear.
  input wire logic ZONE1_LIMIT_FLAG, // Zone 1 flag.
  input wire logic ZONE2_LIMIT_FLAG, // Zone 2 flag.
  input wire logic FAN_SLOW_FLAG,    // Fan flag.
  input wire logic LOCK_SET,         // Lock request.
  input wire logic WRITE_LOCKED,     // Lock state.
  input wire logic TACH_3WIRE_EN,    // Tach hold enable.
  input wire logic TACH_SAMPLING,    // Reading in progress.
  input wire logic FAN_PWM           // Fan pin.
);
  // One domain, so clock and reset are given once; flags only move on a sample or a clear.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  z1_flag_cause_a: assert property ($rose(ZONE1_LIMIT_FLAG) |-> $past(TEMP_VALID)) else $error("zone 1 flag rose without sample");
  z2_flag_cause_a: assert property ($rose(ZONE2_LIMIT_FLAG) |-> $past(TEMP_VALID)) else $error("zone 2 flag rose without sample");
  fan_flag_cause_a: assert property ($rose(FAN_SLOW_FLAG) |-> $past(TACH_VALID)) else $error("fan flag rose without reading");
  flag_clear_a: assert property (STATUS_CLEAR && !TEMP_VALID && !TACH_VALID |=> !(ZONE1_LIMIT_FLAG || ZONE2_LIMIT_FLAG || FAN_SLOW_FLAG)) else $error("flags survived clear");
  flag_sticky_a: assert property (FAN_SLOW_FLAG && !STATUS_CLEAR |=> FAN_SLOW_FLAG) else $error("fan flag dropped");
  lock_set_a: assert property (LOCK_SET |-> ##[1:2] WRITE_LOCKED) else $error("lock not taken");
  lock_sticky_a: assert property (WRITE_LOCKED |=> WRITE_LOCKED) else $error("lock cleared");
  tach_hold_a: assert property ((TACH_3WIRE_EN && TACH_SAMPLING) [*3] |-> FAN_PWM) else $error("pin low in tach reading");
  cover property (ZONE1_LIMIT_FLAG);
  cover property (FAN_SLOW_FLAG);
  cover property (WRITE_LOCKED);
endmodule
bind fpzl_top fpzl_top_asserts u_chk (.CLK(CLK), .RST_N(RST_N), .TEMP_VALID(TEMP_VALID),
  .TACH_VALID(TACH_VALID), .STATUS_CLEAR(STATUS_CLEAR), .ZONE1_LIMIT_FLAG(ZONE1_LIMIT_FLAG),
  .ZONE2_LIMIT_FLAG(ZONE2_LIMIT_FLAG), .FAN_SLOW_FLAG(FAN_SLOW_FLAG), .LOCK_SET(LOCK_SET),
  .WRITE_LOCKED(WRITE_LOCKED), .TACH_3WIRE_EN(TACH_3WIRE_EN), .TACH_SAMPLING(TACH_SAMPLING),
  .FAN_PWM(FAN_PWM));

// ==== bench/fpzl_top_test.sv ====
/* Self-checking bench of fpzl_top: registers, limits, modes, PWM, tach, lock.
   Assumes the fan model in fpzl_fan_model and SPIN_MS_CYCLES of 4. */
`timescale 1ns/10ps
// ======================================================================
module fpzl_top_test;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, apply = 0, lock = 0, force_full = 0, en3 = 0;
  logic tv = 0, clr = 0, meas = 0, samp, tvld, f1, f2, fs, wl, pwm;
  logic [7:0] addr = 8'h0, wdata = 8'h0, z1d = 8'h0, z2d = 8'h0, rdata;
  logic signed [7:0] z1t = 8'sh0, z2t = 8'sh0;
  logic [15:0] per = 16'h0, tc;
  int fails = 0, num_checks = 0;
  fpzl_top #(.SPIN_MS_CYCLES(4)) dut (.CLK(clk), .RST_N(rst_n), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .APPLY_SETTINGS(apply),
    .LOCK_SET(lock), .FORCE_FULL_DUTY(force_full), .TACH_3WIRE_EN(en3), .TACH_SAMPLING(samp),
    .ZONE1_TEMP(z1t), .ZONE2_TEMP(z2t), .TEMP_VALID(tv), .ZONE1_AUTO_DUTY(z1d),
    .ZONE2_AUTO_DUTY(z2d), .TACH_COUNT(tc), .TACH_VALID(tvld), .STATUS_CLEAR(clr),
    .ZONE1_LIMIT_FLAG(f1), .ZONE2_LIMIT_FLAG(f2), .FAN_SLOW_FLAG(fs), .WRITE_LOCKED(wl),
    .FAN_PWM(pwm));
  fpzl_fan_model fan (.clk(clk), .measure(meas), .period(per), .sampling(samp),
    .tach_valid(tvld), .tach_count(tc));
  initial forever #12.5 clk = ~clk;
  // A hang ends the run as a failure.
  initial begin repeat (60000) @(posedge clk); fails++; tally_and_finish; end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin fails++; $display("unexpected %s expected %h seen %h", n, e, s); end
  endtask
  task automatic wr_(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1; @(posedge clk); wr <= 0;
  endtask
  task automatic rd_(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk); addr <= a; rd <= 1; @(posedge clk); rd <= 0; @(posedge clk); #1;
    chk("rdata", {8'h0, rdata}, {8'h0, e});
  endtask
  task automatic temp_(input logic [7:0] a, input logic [7:0] b, input logic e1, input logic e2);
    @(posedge clk); z1t <= a; z2t <= b; tv <= 1; @(posedge clk); tv <= 0; @(posedge clk); #1;
    chk("zone flags", {14'h0, f1, f2}, {14'h0, e1, e2});
    @(posedge clk); clr <= 1; @(posedge clk); clr <= 0;
  endtask
  task automatic tach_(input logic [15:0] p, input logic e);
    @(posedge clk); per <= p; meas <= 1; @(posedge clk); meas <= 0; repeat (8) @(posedge clk);
    #1 chk("fan flag", {15'h0, fs}, {15'h0, e});
    @(posedge clk); clr <= 1; @(posedge clk); clr <= 0;
  endtask
  task automatic pwm_(input int e);
    logic [15:0] n;
    n = 16'h0000;
    repeat (600) @(posedge clk);
    repeat (256) begin @(posedge clk); #1; n += pwm; end
    chk("pwm highs", n, e[15:0]);
  endtask
  // Reset values, zone limits, mode table, PWM, spin-up, tach alarm and lock, in that order.
  initial begin
    static logic [7:0] ofs[9] = '{8'h30, 8'h4e, 8'h4f, 8'h50, 8'h51, 8'h54, 8'h55, 8'h5c, 8'h00};
    static logic [7:0] rst[9] = '{8'hff, 8'h81, 8'h7f, 8'h81, 8'h7f, 8'hff, 8'hff, 8'h62, 8'h00};
    static logic [7:0] dut_exp[8] = '{8'h40, 8'hc0, 8'hff, 8'hff, 8'h00, 8'hc0, 8'hc0, 8'hff};
    repeat (10) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 9; i++) rd_(ofs[i], rst[i]);
    wr_(8'h4f, 8'h32); temp_(8'h33, 8'h00, 1, 0);
    temp_(8'h80, 8'h7f, 1, 0); temp_(8'h00, 8'h80, 0, 1);
    wr_(8'h30, 8'h11); rd_(8'h30, 8'hff);
    z1d <= 8'h40; z2d <= 8'hc0; wr_(8'h5c, 8'h00); rd_(8'h30, 8'hff);
    apply <= 1;
    for (int m = 0; m < 8; m++) begin wr_(8'h5c, {m[2:0], 5'h0}); rd_(8'h30, dut_exp[m]); end
    wr_(8'h30, 8'h55); rd_(8'h30, 8'h55);
    wr_(8'h5c, 8'hc0); z1d <= 8'hd0; rd_(8'h30, 8'hd0); z1d <= 8'h40;
    wr_(8'h5c, 8'h80); force_full <= 1; rd_(8'h30, 8'hff);
    force_full <= 0; rd_(8'h30, 8'h00);
    wr_(8'h5c, 8'h90); pwm_(256);
    wr_(8'h5c, 8'h01); rd_(8'h30, 8'hff); repeat (420) @(posedge clk); rd_(8'h30, 8'h40);
    z1d <= 8'h80; pwm_(128);
    z1d <= 8'hff; wr_(8'h5c, 8'h10); pwm_(0);
    z1d <= 8'h40; en3 <= 1; wr_(8'h54, 8'h03); wr_(8'h55, 8'h10);
    repeat (8) @(posedge clk); tach_(16'h1000, 1); tach_(16'h1003, 0);
    z1d <= 8'h00; repeat (8) @(posedge clk); tach_(16'h0000, 0);
    z1d <= 8'h40; wr_(8'h54, 8'hff); wr_(8'h55, 8'hff); tach_(16'h0000, 0);
    @(posedge clk); lock <= 1; @(posedge clk); lock <= 0; wr_(8'h5c, 8'h00); rd_(8'h5c, 8'h10);
    wr_(8'h4e, 8'h05); rd_(8'h4e, 8'h05); chk("lock", {15'h0, wl}, 16'h1);
    tally_and_finish;
  end
endmodule

// ==== hw/fpzl_pkg.sv ====
/*
  Package of the fan PWM and zone limit control block: register offsets,
  reset values, field positions, mode codes and timing figures.
  Assumes a single 40 MHz device clock; nothing else is shared.
*/
package fpzl_pkg;

  // ==========================================================================
  // Register offsets on the register access port.
  localparam logic [7:0] OFS_LIVE_DUTY   = 8'h30;
  localparam logic [7:0] OFS_Z1_LOWER    = 8'h4e;
  localparam logic [7:0] OFS_Z1_UPPER    = 8'h4f;
  localparam logic [7:0] OFS_Z2_LOWER    = 8'h50;
  localparam logic [7:0] OFS_Z2_UPPER    = 8'h51;
  localparam logic [7:0] OFS_FLOOR_LOW   = 8'h54;
  localparam logic [7:0] OFS_FLOOR_HIGH  = 8'h55;
  localparam logic [7:0] OFS_FAN_CFG     = 8'h5c;

  // ==========================================================================
  // Values after reset.
  localparam logic [7:0] RST_LIVE_DUTY   = 8'hff;
  localparam logic [7:0] RST_MANUAL_DUTY = 8'hff;
  localparam logic [7:0] RST_LOWER       = 8'h81;
  localparam logic [7:0] RST_UPPER       = 8'h7f;
  localparam logic [7:0] RST_FLOOR_BYTE  = 8'hff;
  localparam logic [7:0] RST_FAN_CFG     = 8'h62;
  localparam logic [7:0] RST_RDATA       = 8'h00;

  // ==========================================================================
  // Duty encoding and special values.
  localparam logic [7:0]  DUTY_ZERO      = 8'h00;
  localparam logic [7:0]  DUTY_FULL      = 8'hff;
  localparam logic [15:0] FLOOR_NEVER    = 16'hffff;

  // ==========================================================================
  // Field positions inside the fan configuration register.
  localparam int SRC_SEL_MSB  = 7;
  localparam int SRC_SEL_LSB  = 5;
  localparam int POL_FLIP_BIT = 4;
  localparam int SPIN_MSB     = 2;
  localparam int SPIN_LSB     = 0;

  // Codes of the three-bit source select field.
  localparam logic [2:0] SRC_ZONE1    = 3'h0;
  localparam logic [2:0] SRC_ZONE2    = 3'h1;
  localparam logic [2:0] SRC_RESERVED = 3'h2;
  localparam logic [2:0] SRC_FULL     = 3'h3;
  localparam logic [2:0] SRC_DISABLED = 3'h4;
  localparam logic [2:0] SRC_ZONE2_B  = 3'h5;
  localparam logic [2:0] SRC_HOTTEST  = 3'h6;
  localparam logic [2:0] SRC_MANUAL   = 3'h7;

  // ==========================================================================
  // Timing: clock rate, one millisecond in cycles, spin-up times in ms.
  localparam int CLK_HZ        = 40000000;
  localparam int MS_PER_S      = 1000;
  localparam int MS_CYCLES     = CLK_HZ / MS_PER_S;
  localparam int SPIN_MS_0     = 0;
  localparam int SPIN_MS_1     = 100;
  localparam int SPIN_MS_2     = 250;
  localparam int SPIN_MS_3     = 400;
  localparam int SPIN_MS_4     = 700;
  localparam int SPIN_MS_5     = 1000;
  localparam int SPIN_MS_6     = 2000;
  localparam int SPIN_MS_7     = 4000;
  localparam logic [31:0] SPIN_CNT_ZERO = 32'h0000_0000;
  localparam logic [7:0]  PWM_CNT_ZERO  = 8'h00;

  // Spin-up state of the fan.
  typedef enum logic [1:0] {FPZL_STOPPED, FPZL_SPINUP, FPZL_RUNNING} fpzl_spin_t;

endpackage

// ==== hw/fpzl_pwm_gen.sv ====
/*
  PWM waveform generator for the fan output. Takes a requested duty and
  the polarity flip, and produces the pin level from a flip-flop.
  Assumes the requested duty is stable or changes only between periods
  of interest; it is taken at the period boundary.
*/
`timescale 1ns/10ps

module fpzl_pwm_gen (
  input  wire logic       clk,         // Device clock.
  input  wire logic       rst_n,       // Asynchronous reset, active low.
  input  wire logic [7:0] duty_req,    // Requested duty, 8-bit fraction.
  input  wire logic       pol_flip,    // Invert the output when set.
  input  wire logic       hold_idle,   // Hold the inactive level.
  input  wire logic       hold_high,   // Hold the pin high for a tach reading.
  output logic            pwm_pin,     // Pin level.
  output logic            period_end   // Pulse on the next-to-last count of a period.
);

  // ==========================================================================
  // Period counter and latched duty.
  logic [7:0] cnt;
  logic [7:0] duty_act;
  logic       active;
  logic       next_pin;

  // New duty is latched on period_end and takes effect one count before the wrap.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= fpzl_pkg::PWM_CNT_ZERO;
      duty_act <= fpzl_pkg::DUTY_FULL;
      pwm_pin  <= 1'b1;
    end else begin
      cnt     <= cnt + 8'h01;
      pwm_pin <= next_pin;
      if (period_end) begin
        duty_act <= duty_req;
      end
    end
  end

  assign period_end = (cnt == 8'hfe);

  // Full duty is a constant level; otherwise high for duty of 256 counts.
  assign active   = (duty_act == fpzl_pkg::DUTY_FULL) || (cnt < duty_act);
  assign next_pin = hold_high ? 1'b1 :
                    hold_idle ? pol_flip :
                    (active ^ pol_flip);

endmodule

// ==== hw/fpzl_top.sv ====
/*
  Fan PWM and zone limit control: the register file of the fan block,
  zone limit comparison, tachometer floor check, source selection,
  spin-up and the PWM output to the fan.
  Assumes register accesses arrive already decoded from the two-wire
  interface as one-cycle read and write strobes, that zone temperatures
  and tachometer counts come with one-cycle valid pulses, and that the
  automatic duty per zone is computed outside this block.
*/
`timescale 1ns/10ps

module fpzl_top #(
  parameter int SPIN_MS_CYCLES = fpzl_pkg::MS_CYCLES  // Cycles in one millisecond.
) (
  input  wire logic              CLK,           // Device clock, 40 MHz.
  input  wire logic              RST_N,         // Asynchronous reset, active low.
  input  wire logic [7:0]        REG_ADDR,      // Register offset.
  input  wire logic [7:0]        REG_WDATA,     // Write data.
  input  wire logic              REG_WR,        // Write strobe, one cycle.
  input  wire logic              REG_RD,        // Read strobe, one cycle.
  output logic      [7:0]        REG_RDATA,     // Read data, one cycle after strobe.
  input  wire logic              APPLY_SETTINGS,// Use programmed settings.
  input  wire logic              LOCK_SET,      // Pulse that sets the lock latch.
  input  wire logic              FORCE_FULL_DUTY, // Override to full duty.
  input  wire logic              TACH_3WIRE_EN, // Three-wire tach measurement.
  input  wire logic              TACH_SAMPLING, // A tach reading is being taken.
  input  wire logic signed [7:0] ZONE1_TEMP,    // Remote diode temperature.
  input  wire logic signed [7:0] ZONE2_TEMP,    // On-die temperature.
  input  wire logic              TEMP_VALID,    // New temperatures, one cycle.
  input  wire logic [7:0]        ZONE1_AUTO_DUTY, // Automatic duty for zone 1.
  input  wire logic [7:0]        ZONE2_AUTO_DUTY, // Automatic duty for zone 2.
  input  wire logic [15:0]       TACH_COUNT,    // Tachometer reading.
  input  wire logic              TACH_VALID,    // New tach reading, one cycle.
  input  wire logic              STATUS_CLEAR,  // Clears the status flags.
  output logic                   ZONE1_LIMIT_FLAG, // Zone 1 out of bounds.
  output logic                   ZONE2_LIMIT_FLAG, // Zone 2 out of bounds.
  output logic                   FAN_SLOW_FLAG, // Tach below floor.
  output logic                   WRITE_LOCKED,  // Lock latch state.
  output logic                   FAN_PWM        // Fan drive pin.
);

  // ==========================================================================
  // Register storage.
  logic [7:0] live_fan_duty;
  logic [7:0] manual_duty;
  logic [7:0] zone1_lower_bound;
  logic [7:0] zone1_upper_bound;
  logic [7:0] zone2_lower_bound;
  logic [7:0] zone2_upper_bound;
  logic [7:0] speed_floor_low_byte;
  logic [7:0] speed_floor_high_byte;
  logic [7:0] fan_source_and_startup;
  logic       lock_latch;

  // ==========================================================================
  // Configuration in effect and mode decode.
  logic [7:0] cfg_used;
  logic [2:0] fan_source_select;
  logic       output_polarity_flip;
  logic [2:0] spin_sel;
  logic       mode_disabled;
  logic       mode_manual;
  logic [7:0] hottest_duty;
  logic [7:0] source_duty;
  logic [7:0] next_live_duty;

  // Stored value follows writes while unlocked; it is only used once applied.
  assign cfg_used             = APPLY_SETTINGS ? fan_source_and_startup
                                               : fpzl_pkg::RST_FAN_CFG;
  assign fan_source_select    = cfg_used[fpzl_pkg::SRC_SEL_MSB:fpzl_pkg::SRC_SEL_LSB];
  assign output_polarity_flip = cfg_used[fpzl_pkg::POL_FLIP_BIT];
  assign spin_sel             = cfg_used[fpzl_pkg::SPIN_MSB:fpzl_pkg::SPIN_LSB];
  assign mode_disabled        = (fan_source_select == fpzl_pkg::SRC_DISABLED);
  assign mode_manual          = (fan_source_select == fpzl_pkg::SRC_MANUAL);

  // Duties are compared, not temperatures, so each zone's own curve counts.
  assign hottest_duty = (ZONE1_AUTO_DUTY > ZONE2_AUTO_DUTY) ? ZONE1_AUTO_DUTY
                                                            : ZONE2_AUTO_DUTY;

  // Source selection. Reserved code runs the fan full as the safe choice.
  always_comb begin
    unique case (fan_source_select)
      fpzl_pkg::SRC_ZONE1:    source_duty = ZONE1_AUTO_DUTY;
      fpzl_pkg::SRC_ZONE2,
      fpzl_pkg::SRC_ZONE2_B:  source_duty = ZONE2_AUTO_DUTY;
      fpzl_pkg::SRC_RESERVED: source_duty = fpzl_pkg::DUTY_FULL;
      fpzl_pkg::SRC_FULL:     source_duty = fpzl_pkg::DUTY_FULL;
      fpzl_pkg::SRC_DISABLED: source_duty = fpzl_pkg::DUTY_ZERO;
      fpzl_pkg::SRC_HOTTEST:  source_duty = hottest_duty;
      fpzl_pkg::SRC_MANUAL:   source_duty = manual_duty;
    endcase
  end

  // ==========================================================================
  // Spin-up of a stationary fan.
  fpzl_pkg::fpzl_spin_t spin_state;
  fpzl_pkg::fpzl_spin_t next_spin_state;
  logic [31:0]          spin_cnt;
  logic [31:0]          next_spin_cnt;
  logic [31:0]          spin_ms;
  logic [31:0]          spin_load;
  logic                 wants_run;

  // Table of spin-up times; the product stays well below 2**31 at 40 MHz.
  always_comb begin
    unique case (spin_sel)
      3'h0:    spin_ms = 32'(fpzl_pkg::SPIN_MS_0);
      3'h1:    spin_ms = 32'(fpzl_pkg::SPIN_MS_1);
      3'h2:    spin_ms = 32'(fpzl_pkg::SPIN_MS_2);
      3'h3:    spin_ms = 32'(fpzl_pkg::SPIN_MS_3);
      3'h4:    spin_ms = 32'(fpzl_pkg::SPIN_MS_4);
      3'h5:    spin_ms = 32'(fpzl_pkg::SPIN_MS_5);
      3'h6:    spin_ms = 32'(fpzl_pkg::SPIN_MS_6);
      3'h7:    spin_ms = 32'(fpzl_pkg::SPIN_MS_7);
    endcase
  end

  assign spin_load = 32'(spin_ms * 32'(SPIN_MS_CYCLES));
  assign wants_run = !mode_disabled && (source_duty != fpzl_pkg::DUTY_ZERO);

  // A fan that was asked to stop is assumed stationary when asked to run again.
  always_comb begin
    next_spin_state = spin_state;
    next_spin_cnt   = spin_cnt;
    unique case (spin_state)
      fpzl_pkg::FPZL_STOPPED: begin
        if (wants_run && (spin_load != fpzl_pkg::SPIN_CNT_ZERO)) begin
          next_spin_state = fpzl_pkg::FPZL_SPINUP;
          next_spin_cnt   = spin_load;
        end else if (wants_run) begin
          next_spin_state = fpzl_pkg::FPZL_RUNNING;
        end
      end
      fpzl_pkg::FPZL_SPINUP: begin
        if (!wants_run) begin
          next_spin_state = fpzl_pkg::FPZL_STOPPED;
          next_spin_cnt   = fpzl_pkg::SPIN_CNT_ZERO;
        end else if (spin_cnt <= 32'h0000_0001) begin
          next_spin_state = fpzl_pkg::FPZL_RUNNING;
          next_spin_cnt   = fpzl_pkg::SPIN_CNT_ZERO;
        end else begin
          next_spin_cnt   = spin_cnt - 32'h0000_0001;
        end
      end
      fpzl_pkg::FPZL_RUNNING: begin
        if (!wants_run) begin
          next_spin_state = fpzl_pkg::FPZL_STOPPED;
        end
      end
    endcase
  end

  // Reset leaves the fan treated as running: it already starts at full duty.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      spin_state <= fpzl_pkg::FPZL_RUNNING;
      spin_cnt   <= fpzl_pkg::SPIN_CNT_ZERO;
    end else begin
      spin_state <= next_spin_state;
      spin_cnt   <= next_spin_cnt;
    end
  end

  // ==========================================================================
  // Live duty: override first, then spin-up, then the selected source.
  assign next_live_duty = FORCE_FULL_DUTY ? fpzl_pkg::DUTY_FULL :
                          (next_spin_state == fpzl_pkg::FPZL_SPINUP) ? fpzl_pkg::DUTY_FULL :
                          source_duty;

  // Reset value is full duty so the fan is safe before software acts.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      live_fan_duty <= fpzl_pkg::RST_LIVE_DUTY;
    end else begin
      live_fan_duty <= next_live_duty;
    end
  end

  // ==========================================================================
  // Register write decode.
  logic wr_live;
  logic wr_z1_lo;
  logic wr_z1_hi;
  logic wr_z2_lo;
  logic wr_z2_hi;
  logic wr_fl_lo;
  logic wr_fl_hi;
  logic wr_cfg;

  assign wr_live  = REG_WR && (REG_ADDR == fpzl_pkg::OFS_LIVE_DUTY) && mode_manual;
  assign wr_z1_lo = REG_WR && (REG_ADDR == fpzl_pkg::OFS_Z1_LOWER);
  assign wr_z1_hi = REG_WR && (REG_ADDR == fpzl_pkg::OFS_Z1_UPPER);
  assign wr_z2_lo = REG_WR && (REG_ADDR == fpzl_pkg::OFS_Z2_LOWER);
  assign wr_z2_hi = REG_WR && (REG_ADDR == fpzl_pkg::OFS_Z2_UPPER);
  assign wr_fl_lo = REG_WR && (REG_ADDR == fpzl_pkg::OFS_FLOOR_LOW);
  assign wr_fl_hi = REG_WR && (REG_ADDR == fpzl_pkg::OFS_FLOOR_HIGH);
  assign wr_cfg   = REG_WR && (REG_ADDR == fpzl_pkg::OFS_FAN_CFG) && !lock_latch;

  // Bounds and floor ignore the lock; the configuration honours it.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      manual_duty            <= fpzl_pkg::RST_MANUAL_DUTY;
      zone1_lower_bound      <= fpzl_pkg::RST_LOWER;
      zone1_upper_bound      <= fpzl_pkg::RST_UPPER;
      zone2_lower_bound      <= fpzl_pkg::RST_LOWER;
      zone2_upper_bound      <= fpzl_pkg::RST_UPPER;
      speed_floor_low_byte   <= fpzl_pkg::RST_FLOOR_BYTE;
      speed_floor_high_byte  <= fpzl_pkg::RST_FLOOR_BYTE;
      fan_source_and_startup <= fpzl_pkg::RST_FAN_CFG;
    end else begin
      if (wr_live)  manual_duty            <= REG_WDATA;
      if (wr_z1_lo) zone1_lower_bound      <= REG_WDATA;
      if (wr_z1_hi) zone1_upper_bound      <= REG_WDATA;
      if (wr_z2_lo) zone2_lower_bound      <= REG_WDATA;
      if (wr_z2_hi) zone2_upper_bound      <= REG_WDATA;
      if (wr_fl_lo) speed_floor_low_byte   <= REG_WDATA;
      if (wr_fl_hi) speed_floor_high_byte  <= REG_WDATA;
      if (wr_cfg)   fan_source_and_startup <= REG_WDATA;
    end
  end

  // Lock only sets; nothing but reset (power removal) clears it.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_latch <= 1'b0;
    end else if (LOCK_SET) begin
      lock_latch <= 1'b1;
    end
  end

  // ==========================================================================
  // Register read path; unmapped offsets read zero.
  logic [7:0] rd_mux;

  always_comb begin
    unique case (REG_ADDR)
      fpzl_pkg::OFS_LIVE_DUTY:  rd_mux = live_fan_duty;
      fpzl_pkg::OFS_Z1_LOWER:   rd_mux = zone1_lower_bound;
      fpzl_pkg::OFS_Z1_UPPER:   rd_mux = zone1_upper_bound;
      fpzl_pkg::OFS_Z2_LOWER:   rd_mux = zone2_lower_bound;
      fpzl_pkg::OFS_Z2_UPPER:   rd_mux = zone2_upper_bound;
      fpzl_pkg::OFS_FLOOR_LOW:  rd_mux = speed_floor_low_byte;
      fpzl_pkg::OFS_FLOOR_HIGH: rd_mux = speed_floor_high_byte;
      fpzl_pkg::OFS_FAN_CFG:    rd_mux = fan_source_and_startup;
      default:                  rd_mux = 8'h00;
    endcase
  end

  // Read data holds until the next read strobe.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= fpzl_pkg::RST_RDATA;
    end else if (REG_RD) begin
      REG_RDATA <= rd_mux;
    end
  end

  // ==========================================================================
  // Zone limit checks, taken on each new temperature sample.
  logic z1_out;
  logic z2_out;
  logic [15:0] speed_floor;
  logic fan_slow;

  // Zone 1 is the remote diode input, zone 2 the on-die sensor.
  assign z1_out = (ZONE1_TEMP > $signed(zone1_upper_bound)) ||
                  (ZONE1_TEMP < $signed(zone1_lower_bound));
  assign z2_out = (ZONE2_TEMP > $signed(zone2_upper_bound)) ||
                  (ZONE2_TEMP < $signed(zone2_lower_bound));

  // Alarm masked when the fan is meant to be still or the floor is disarmed.
  assign speed_floor = {speed_floor_high_byte, speed_floor_low_byte};
  assign fan_slow    = (TACH_COUNT < speed_floor) &&
                       (live_fan_duty != fpzl_pkg::DUTY_ZERO) &&
                       !mode_disabled &&
                       (speed_floor != fpzl_pkg::FLOOR_NEVER);

  // Flags are sticky; a new event in the clear cycle wins over the clear.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ZONE1_LIMIT_FLAG <= 1'b0;
      ZONE2_LIMIT_FLAG <= 1'b0;
      FAN_SLOW_FLAG    <= 1'b0;
    end else begin
      if (TEMP_VALID && z1_out) begin
        ZONE1_LIMIT_FLAG <= 1'b1;
      end else if (STATUS_CLEAR) begin
        ZONE1_LIMIT_FLAG <= 1'b0;
      end
      if (TEMP_VALID && z2_out) begin
        ZONE2_LIMIT_FLAG <= 1'b1;
      end else if (STATUS_CLEAR) begin
        ZONE2_LIMIT_FLAG <= 1'b0;
      end
      if (TACH_VALID && fan_slow) begin
        FAN_SLOW_FLAG <= 1'b1;
      end else if (STATUS_CLEAR) begin
        FAN_SLOW_FLAG <= 1'b0;
      end
    end
  end

  // Lock state mirrored to a port for the status logic around the block.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WRITE_LOCKED <= 1'b0;
    end else begin
      WRITE_LOCKED <= lock_latch;
    end
  end

  // ==========================================================================
  // PWM output. The tach hold raises low duties and may be heard.
  logic hold_idle;
  logic hold_high;

  assign hold_idle = mode_disabled && !FORCE_FULL_DUTY;
  assign hold_high = TACH_3WIRE_EN && TACH_SAMPLING;

  fpzl_pwm_gen u_pwm (
    .clk        (CLK),
    .rst_n      (RST_N),
    .duty_req   (live_fan_duty),
    .pol_flip   (output_polarity_flip),
    .hold_idle  (hold_idle),
    .hold_high  (hold_high),
    .pwm_pin    (FAN_PWM),
    .period_end ()
  );

endmodule
